//--- inc/dpwm_pkg.sv
`default_nettype none
package dpwm_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_PERIOD_A  = 8'h04;
  localparam logic [7:0]  OFF_PERIOD_B  = 8'h08;
  localparam logic [7:0]  OFF_TIMER_A   = 8'h0c;
  localparam logic [7:0]  OFF_TIMER_B   = 8'h10;
  localparam logic [7:0]  OFF_A_DUTY_HI = 8'h14;
  localparam logic [7:0]  OFF_A_DUTY_LO = 8'h18;
  localparam logic [7:0]  OFF_B_DUTY_HI = 8'h1c;
  localparam logic [7:0]  OFF_B_DUTY_LO = 8'h20;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h24;
  localparam logic [7:0]  OFF_INT_MASK  = 8'h28;
  localparam logic [7:0]  OFF_STATUS    = 8'h2c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_A_BIT = 0;
  localparam int unsigned CTRL_EN_B_BIT = 1;
  localparam int unsigned DLO_SEL_BIT   = 5;
  localparam int unsigned DLO_MSB       = 7;
  localparam int unsigned DLO_LSB       = 6;
  localparam int unsigned EVT_A_BIT     = 0;
  localparam int unsigned EVT_B_BIT     = 1;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_CTRL      = 2'h0;
  localparam logic [7:0]  RST_PERIOD    = 8'hff;
  localparam logic [1:0]  RST_MASK      = 2'h0;
  localparam logic [1:0]  Q_LAST        = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] high;
    logic [1:0] low;
  } dpwm_duty_s;
  typedef struct packed {
    logic [7:0] count;
    logic [1:0] phase;
  } dpwm_tick_s;
endpackage : dpwm_pkg
`default_nettype wire

//--- rtl/dpwm_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module dpwm_timebase (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              enable,
  input  wire logic [7:0]        period,
  output var  dpwm_pkg::dpwm_tick_s tick,
  output var  logic              wrap
);
  // ----------------------------------------------------------------
  // Q-clock phase and 8-bit count, self-contained
  // ----------------------------------------------------------------
  // No carry output: the two timers can never be joined into one 16-bit timer
  logic rollover;
  assign rollover = enable && (tick.phase == dpwm_pkg::Q_LAST) && (tick.count == period);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick <= '0;
    end else if (rollover) begin
      tick <= '0;
    end else if (enable) begin
      if (tick.phase == dpwm_pkg::Q_LAST) begin
        tick.count <= tick.count + 8'h01;
      end
      tick.phase <= tick.phase + 2'h1;
    end
  end

  // One-cycle marker of the first Q-clock of a new period
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrap <= 1'b0;
    end else begin
      wrap <= rollover;
    end
  end
endmodule : dpwm_timebase
`default_nettype wire

//--- rtl/dpwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dpwm_channel (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 wrHigh,
  input  wire logic                 wrLow,
  input  wire logic [7:0]           wrData,
  input  wire dpwm_pkg::dpwm_tick_s tick,
  input  wire logic                 wrap,
  output var  dpwm_pkg::dpwm_duty_s slave,
  output var  logic                 pulse
);
  dpwm_pkg::dpwm_duty_s master_r;

  // ----------------------------------------------------------------
  // Master latches take software writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      master_r <= '0;
    end else begin
      if (wrHigh) begin
        master_r.high <= wrData;
      end
      if (wrLow) begin
        master_r.low <= wrData[dpwm_pkg::DLO_MSB:dpwm_pkg::DLO_LSB];
      end
    end
  end

  // Slave only moves at a period start, so a period never sees a torn value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slave <= '0;
    end else if (wrap) begin
      slave <= master_r;
    end
  end

  // ----------------------------------------------------------------
  // High while 10-bit position is below duty, one Tosc per step
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulse <= 1'b0;
    end else if (wrap) begin
      pulse <= (master_r != '0);
    end else begin
      pulse <= ({tick.count, tick.phase} < {slave.high, slave.low});
    end
  end
endmodule : dpwm_channel
`default_nettype wire

//--- rtl/dpwm_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Output A period is (period A plus one) times four oscillator periods.
// - Output B uses timer A when select bit 5 clear, else timer B.
// - Timers A and B are never chained into one 16-bit timer.
// - Duty is 10 bits: high register above, low register bits 7:6 below.
// - Output stays high for duty value oscillator periods from period start.
// - Duty zero keeps the output low for the whole period.
// - Period equal to duty high leaves one to four low oscillator periods.
// - Full duty only when duty high exceeds selected period.
// - Writes fill master latches; rollover copies to slave and forces high unless master duty is zero.
// - Duty register reads return slave latches.
// - Resolution is log2 of oscillator over output frequency; 10 bits at 0xff.
// - Timer equal to period clears to zero, flags event, starts period.
module dpwm_top #(
  parameter int unsigned ADDR_W = dpwm_pkg::ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  output var  logic              pulseOutA,
  output var  logic              pulseOutB,
  output var  logic              irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]    awAddr_r;
  logic                 awHeld_r;
  logic [7:0]           wData_r;
  logic                 wLane0_r;
  logic                 wHeld_r;
  logic                 awTake;
  logic                 wTake;
  logic                 doWrite;
  logic                 awHeld_nxt;
  logic                 wHeld_nxt;
  logic                 bvalid_nxt;
  logic                 arTake;
  logic                 rvalid_nxt;
  logic                 wrHit;
  logic [1:0]           ctrl_r;
  logic [7:0]           periodA_r;
  logic [7:0]           periodB_r;
  logic                 outBSel_r;
  logic [1:0]           intStat_r;
  logic [1:0]           intMask_r;
  logic [1:0]           intSet;
  logic [1:0]           intClr;
  logic                 wrAHigh;
  logic                 wrALow;
  logic                 wrBHigh;
  logic                 wrBLow;
  dpwm_pkg::dpwm_tick_s tickA;
  dpwm_pkg::dpwm_tick_s tickB;
  logic                 wrapA;
  logic                 wrapB;
  dpwm_pkg::dpwm_tick_s tickSelB;
  logic                 wrapSelB;
  dpwm_pkg::dpwm_duty_s slaveA;
  dpwm_pkg::dpwm_duty_s slaveB;
  logic [31:0]          rdMux;
  logic                 rdHit;

  // Word-aligned compare; byte offset bits are ignored
  function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    isReg = ({addr[ADDR_W-1:2], 2'b00} == off);
  endfunction : isReg

  // ----------------------------------------------------------------
  // Write address and data channels, taken in either order
  // ----------------------------------------------------------------
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;
  assign doWrite = awHeld_r && wHeld_r && !bvalid;

  always_comb begin
    awHeld_nxt = (awHeld_r || awTake) && !doWrite;
    wHeld_nxt  = (wHeld_r || wTake) && !doWrite;
    bvalid_nxt = doWrite || (bvalid && !bready);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awAddr_r <= '0;
      awHeld_r <= 1'b0;
      awready  <= 1'b0;
    end else begin
      if (awTake) begin
        awAddr_r <= awaddr;
      end
      awHeld_r <= awHeld_nxt;
      awready  <= !awHeld_nxt && !bvalid_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wData_r  <= '0;
      wLane0_r <= 1'b0;
      wHeld_r  <= 1'b0;
      wready   <= 1'b0;
    end else begin
      if (wTake) begin
        wData_r  <= wdata[7:0];
        wLane0_r <= wstrb[0];
      end
      wHeld_r <= wHeld_nxt;
      wready  <= !wHeld_nxt && !bvalid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_comb begin
    wrHit = isReg(awAddr_r, dpwm_pkg::OFF_CTRL) || isReg(awAddr_r, dpwm_pkg::OFF_PERIOD_A) ||
            isReg(awAddr_r, dpwm_pkg::OFF_PERIOD_B) || isReg(awAddr_r, dpwm_pkg::OFF_TIMER_A) ||
            isReg(awAddr_r, dpwm_pkg::OFF_TIMER_B) || isReg(awAddr_r, dpwm_pkg::OFF_A_DUTY_HI) ||
            isReg(awAddr_r, dpwm_pkg::OFF_A_DUTY_LO) || isReg(awAddr_r, dpwm_pkg::OFF_B_DUTY_HI) ||
            isReg(awAddr_r, dpwm_pkg::OFF_B_DUTY_LO) || isReg(awAddr_r, dpwm_pkg::OFF_INT_STAT) ||
            isReg(awAddr_r, dpwm_pkg::OFF_INT_MASK) || isReg(awAddr_r, dpwm_pkg::OFF_STATUS);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp  <= dpwm_pkg::RESP_OKAY;
    end else begin
      bvalid <= bvalid_nxt;
      if (doWrite) begin
        bresp <= wrHit ? dpwm_pkg::RESP_OKAY : dpwm_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; other lanes are ignored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r    <= dpwm_pkg::RST_CTRL;
      periodA_r <= dpwm_pkg::RST_PERIOD;
      periodB_r <= dpwm_pkg::RST_PERIOD;
      intMask_r <= dpwm_pkg::RST_MASK;
    end else if (doWrite && wLane0_r) begin
      if (isReg(awAddr_r, dpwm_pkg::OFF_CTRL)) begin
        ctrl_r <= wData_r[1:0];
      end
      if (isReg(awAddr_r, dpwm_pkg::OFF_PERIOD_A)) begin
        periodA_r <= wData_r;
      end
      if (isReg(awAddr_r, dpwm_pkg::OFF_PERIOD_B)) begin
        periodB_r <= wData_r;
      end
      if (isReg(awAddr_r, dpwm_pkg::OFF_INT_MASK)) begin
        intMask_r <= wData_r[1:0];
      end
    end
  end

  // Select acts at once, not at rollover; switching mid-period may shorten it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outBSel_r <= 1'b0;
    end else if (wrBLow) begin
      outBSel_r <= wData_r[dpwm_pkg::DLO_SEL_BIT];
    end
  end

  assign wrAHigh = doWrite && wLane0_r && isReg(awAddr_r, dpwm_pkg::OFF_A_DUTY_HI);
  assign wrALow  = doWrite && wLane0_r && isReg(awAddr_r, dpwm_pkg::OFF_A_DUTY_LO);
  assign wrBHigh = doWrite && wLane0_r && isReg(awAddr_r, dpwm_pkg::OFF_B_DUTY_HI);
  assign wrBLow  = doWrite && wLane0_r && isReg(awAddr_r, dpwm_pkg::OFF_B_DUTY_LO);

  // ----------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------
  dpwm_timebase uTimerA (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (ctrl_r[dpwm_pkg::CTRL_EN_A_BIT]),
    .period   (periodA_r),
    .tick     (tickA),
    .wrap     (wrapA)
  );

  dpwm_timebase uTimerB (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (ctrl_r[dpwm_pkg::CTRL_EN_B_BIT]),
    .period   (periodB_r),
    .tick     (tickB),
    .wrap     (wrapB)
  );

  always_comb begin
    tickSelB = outBSel_r ? tickB : tickA;
    wrapSelB = outBSel_r ? wrapB : wrapA;
  end

  // ----------------------------------------------------------------
  // Pulse channels
  // ----------------------------------------------------------------
  dpwm_channel uChanA (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wrHigh   (wrAHigh),
    .wrLow    (wrALow),
    .wrData   (wData_r),
    .tick     (tickA),
    .wrap     (wrapA),
    .slave    (slaveA),
    .pulse    (pulseOutA)
  );

  dpwm_channel uChanB (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wrHigh   (wrBHigh),
    .wrLow    (wrBLow),
    .wrData   (wData_r),
    .tick     (tickSelB),
    .wrap     (wrapSelB),
    .slave    (slaveB),
    .pulse    (pulseOutB)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    intSet = '0;
    intSet[dpwm_pkg::EVT_A_BIT] = wrapA;
    intSet[dpwm_pkg::EVT_B_BIT] = wrapB;
    intClr = '0;
    if (doWrite && wLane0_r && isReg(awAddr_r, dpwm_pkg::OFF_INT_STAT)) begin
      intClr = wData_r[1:0];
    end
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intStat_r <= '0;
    end else begin
      intStat_r <= (intStat_r & ~intClr) | intSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_r & intMask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    rdHit = 1'b1;
    if (isReg(araddr, dpwm_pkg::OFF_CTRL)) begin
      rdMux[1:0] = ctrl_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_PERIOD_A)) begin
      rdMux[7:0] = periodA_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_PERIOD_B)) begin
      rdMux[7:0] = periodB_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_TIMER_A)) begin
      rdMux[7:0] = tickA.count;
    end else if (isReg(araddr, dpwm_pkg::OFF_TIMER_B)) begin
      rdMux[7:0] = tickB.count;
    end else if (isReg(araddr, dpwm_pkg::OFF_A_DUTY_HI)) begin
      rdMux[7:0] = slaveA.high;
    end else if (isReg(araddr, dpwm_pkg::OFF_A_DUTY_LO)) begin
      rdMux[dpwm_pkg::DLO_MSB:dpwm_pkg::DLO_LSB] = slaveA.low;
    end else if (isReg(araddr, dpwm_pkg::OFF_B_DUTY_HI)) begin
      rdMux[7:0] = slaveB.high;
    end else if (isReg(araddr, dpwm_pkg::OFF_B_DUTY_LO)) begin
      rdMux[dpwm_pkg::DLO_MSB:dpwm_pkg::DLO_LSB] = slaveB.low;
      rdMux[dpwm_pkg::DLO_SEL_BIT] = outBSel_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_INT_STAT)) begin
      rdMux[1:0] = intStat_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_INT_MASK)) begin
      rdMux[1:0] = intMask_r;
    end else if (isReg(araddr, dpwm_pkg::OFF_STATUS)) begin
      rdMux[1:0] = {pulseOutB, pulseOutA};
    end else begin
      rdHit = 1'b0;
    end
  end

  assign arTake     = arvalid && arready;
  assign rvalid_nxt = arTake || (rvalid && !rready);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= dpwm_pkg::RESP_OKAY;
    end else begin
      arready <= !rvalid_nxt;
      rvalid  <= rvalid_nxt;
      if (arTake) begin
        rdata <= rdMux;
        rresp <= rdHit ? dpwm_pkg::RESP_OKAY : dpwm_pkg::RESP_SLVERR;
      end
    end
  end
endmodule : dpwm_top
`default_nettype wire

//--- verif/dpwm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dpwm_chk (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        pulseOutA,
  input wire logic        pulseOutB,
  input wire logic        irq
);
  // ------------------------------------------------------------
  // Pulse outputs
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !pulseOutA && !pulseOutB && !irq)
    else $error("output active right after reset");
  // A rise marks a rollover, and rollovers are at least four cycles apart
  out_a_period_a: assert property ($rose(pulseOutA) |=> (!$rose(pulseOutA)) [*3])
    else $error("output A restarted within four cycles");
  out_b_period_a: assert property ($rose(pulseOutB) |=> (!$rose(pulseOutB)) [*3])
    else $error("output B restarted within four cycles");
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  resp_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  read_turn_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  write_turn_a: assert property (awvalid && awready && wvalid && wready |=> ##[0:2] bvalid)
    else $error("write response late");
endmodule : dpwm_chk
bind dpwm_top dpwm_chk dpwm_chk_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .pulseOutA(pulseOutA), .pulseOutB(pulseOutB), .irq(irq)
);
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pulseOutA, pulseOutB, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        irq0, irq3;
  int          numErrors, testsRun, cycles, hiA, hiB;

  dpwm_top dpwm_top_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pulseOutA(pulseOutA), .pulseOutB(pulseOutB),
    .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic testDone;
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : testDone

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask : chk

  // Address and data offered together, each released once taken
  // Response accepted one edge late so the slave must hold it
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b1;
    @(posedge core_clk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge core_clk);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rsp;
    axiWrite(a, v, rsp);
    chk("bresp", {30'h0, dpwm_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    logic [1:0]  rsp;
    axiRead(a, v, rsp);
    chk(name, exp, v);
  endtask : rdChk

  // Any window of whole periods holds the same number of high cycles
  task automatic measure(input int n);
    hiA = 0;
    hiB = 0;
    repeat (40) @(posedge core_clk);
    repeat (n) begin
      @(posedge core_clk);
      if (pulseOutA === 1'b1) hiA++;
      if (pulseOutB === 1'b1) hiB++;
    end
  endtask : measure

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      $display("ERROR timeout expected done seen hang");
      numErrors++;
      testDone();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hf;
    numErrors = 0;
    testsRun = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdChk(dpwm_pkg::OFF_CTRL, 32'h0, "ctrl");
    rdChk(dpwm_pkg::OFF_PERIOD_A, 32'hff, "periodA");
    rdChk(dpwm_pkg::OFF_PERIOD_B, 32'hff, "periodB");
    rdChk(dpwm_pkg::OFF_INT_MASK, 32'h0, "mask");
    rdChk(dpwm_pkg::OFF_A_DUTY_HI, 32'h0, "dutyHiA");
    chk("pulses", 32'h0, {30'h0, pulseOutA, pulseOutB});
    axiRead(8'h30, d, r);
    chk("unmappedRdResp", {30'h0, dpwm_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmappedRdData", 32'h0, d);
    axiWrite(8'h30, 32'h55, r);
    chk("unmappedWrResp", {30'h0, dpwm_pkg::RESP_SLVERR}, {30'h0, r});
    wr(dpwm_pkg::OFF_PERIOD_A, 32'h3);
    wr(dpwm_pkg::OFF_PERIOD_B, 32'h1);
    wr(dpwm_pkg::OFF_A_DUTY_HI, 32'h1);
    wr(dpwm_pkg::OFF_A_DUTY_LO, 32'hbf);
    rdChk(dpwm_pkg::OFF_A_DUTY_HI, 32'h0, "dutyHiUnrolled");
    wr(dpwm_pkg::OFF_CTRL, 32'h3);
    measure(64);
    rdChk(dpwm_pkg::OFF_A_DUTY_HI, 32'h1, "dutyHiRolled");
    chk("highA", 32'd24, hiA);
    chk("highBZero", 32'd0, hiB);
    wr(dpwm_pkg::OFF_A_DUTY_HI, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(dpwm_pkg::OFF_A_DUTY_LO, 32'(k << 6));
      measure(64);
      chk("highAEqualPeriod", 32'(4 * (12 + k)), hiA);
    end
    wr(dpwm_pkg::OFF_A_DUTY_HI, 32'h4);
    measure(64);
    chk("highAFull", 32'd64, hiA);
    rdChk(dpwm_pkg::OFF_STATUS, 32'h1, "statusFull");
    wr(dpwm_pkg::OFF_A_DUTY_HI, 32'h0);
    wr(dpwm_pkg::OFF_A_DUTY_LO, 32'h0);
    wr(dpwm_pkg::OFF_B_DUTY_HI, 32'h1);
    measure(64);
    chk("highAZero", 32'd0, hiA);
    chk("highBTimerA", 32'd16, hiB);
    wr(dpwm_pkg::OFF_B_DUTY_LO, 32'h20);
    measure(64);
    chk("highBTimerB", 32'd32, hiB);
    wr(dpwm_pkg::OFF_CTRL, 32'h0);
    wr(dpwm_pkg::OFF_INT_STAT, 32'h1);
    rdChk(dpwm_pkg::OFF_INT_STAT, 32'h2, "statPartClear");
    repeat (2) @(posedge core_clk);
    irq0 = irq;
    wr(dpwm_pkg::OFF_INT_MASK, 32'h3);
    repeat (2) @(posedge core_clk);
    irq3 = irq;
    chk("irqMasked", 32'h0, {31'h0, irq0});
    chk("irqUnmasked", 32'h1, {31'h0, irq3});
    wr(dpwm_pkg::OFF_INT_STAT, 32'h3);
    rdChk(dpwm_pkg::OFF_INT_STAT, 32'h0, "statClear");
    repeat (2) @(posedge core_clk);
    chk("irqCleared", 32'h0, {31'h0, irq});
    wstrb <= 4'he;
    wr(dpwm_pkg::OFF_INT_MASK, 32'h0);
    wstrb <= 4'hf;
    rdChk(dpwm_pkg::OFF_INT_MASK, 32'h3, "maskLaneOff");
    testDone();
  end
endmodule : tb
`default_nettype wire
